/* File: rtl/dcq_pkg.sv */
package dcq_pkg;

  // ----------------------------------------------------------------
  // Clock and time constants
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int CLK_PER_US = CLK_HZ / 1000000;
  // Fast and slow input filters, least stable time
  localparam int FAST_FILT_US = 2500;
  localparam int SLOW_FILT_US = 12500;
  localparam int FAST_FILT_CYC = FAST_FILT_US * CLK_PER_US;
  localparam int SLOW_FILT_CYC = SLOW_FILT_US * CLK_PER_US;
  // Timebase granularity for the rate measurement
  localparam int MS_TICK_US = 1000;
  localparam int MS_TICK_CYC = MS_TICK_US * CLK_PER_US;
  // Internal oscillator count source
  localparam int OSC_PERIOD_NS = 1000;
  localparam int OSC_DIV = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int FILT_W = 19;
  localparam int MS_W = 15;
  localparam int OSC_W = 5;
  localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_DIV - 1);

  // ----------------------------------------------------------------
  // Register map, word addresses
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] A_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] A_FSEL = 5'h01;
  localparam logic [ADDR_W-1:0] A_TBASE = 5'h02;
  localparam logic [ADDR_W-1:0] A_FLAG = 5'h03;
  localparam logic [ADDR_W-1:0] A_ACC0 = 5'h04;
  localparam logic [ADDR_W-1:0] A_CAP0 = 5'h06;
  localparam logic [ADDR_W-1:0] A_CPT0 = 5'h0a;
  localparam logic [ADDR_W-1:0] A_PRE0 = 5'h0c;
  localparam logic [ADDR_W-1:0] A_HOME = 5'h0e;
  localparam logic [ADDR_W-1:0] A_ON0 = 5'h0f;
  localparam logic [ADDR_W-1:0] A_OFF0 = 5'h13;

  // Control word fields
  localparam int CTRL_DIFF = 0;
  localparam int CTRL_MODE0 = 1;
  localparam int CTRL_MODE1 = 3;
  localparam int CTRL_OSC = 5;
  localparam int CTRL_SFALL = 6;
  localparam int CTRL_OUTEN = 10;
  localparam int CTRL_HOME = 14;
  // Flag word fields
  localparam int FLG_STB = 0;
  localparam int FLG_PL = 4;
  localparam int FLG_HOME = 6;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [7:0] FSEL_RST = 8'h00;
  localparam logic [15:0] TBASE_RST = 16'h03e8;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    DCQ_UPDN = 2'b00,
    DCQ_PDIR = 2'b01,
    DCQ_QUAD = 2'b10,
    DCQ_OFF = 2'b11
  } dcq_mode_t;

  typedef enum logic [1:0] {
    HOME_IDLE = 2'b00,
    HOME_ARMED = 2'b01,
    HOME_DONE = 2'b10
  } dcq_home_t;

endpackage

/* File: rtl/dcq_cnt_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface dcq_cnt_if;
  logic up;
  logic dn;
  modport dec (output up, output dn);
  modport acc (input up, input dn);
endinterface
`default_nettype wire

/* File: rtl/dcq_filt.sv */
`timescale 1ns/10ps
`default_nettype none
module dcq_filt #(
  parameter int FAST_CYC = dcq_pkg::FAST_FILT_CYC,
  parameter int SLOW_CYC = dcq_pkg::SLOW_FILT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic raw_i,
  input wire logic slow_i,
  output logic level_o
);
  import dcq_pkg::*;

  logic s1;
  logic s2;
  logic s3;
  logic [FILT_W-1:0] cnt;
  logic [FILT_W-1:0] limit;
  logic changed;

  // A change is only a candidate once the last two stages agree
  assign changed = (s2 == s3) && (s3 != level_o);
  assign limit = slow_i ? FILT_W'(SLOW_CYC - 1) : FILT_W'(FAST_CYC - 1);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      cnt <= '0;
      level_o <= 1'b0;
    end else begin
      s1 <= raw_i;
      s2 <= s1;
      s3 <= s2;
      if (!changed) begin
        cnt <= '0;
      end else if (cnt >= limit) begin
        cnt <= '0;
        level_o <= s3;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: rtl/dcq_dec.sv */
`timescale 1ns/10ps
`default_nettype none
module dcq_dec (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic a_i,
  input wire logic b_i,
  input wire dcq_pkg::dcq_mode_t mode_i,
  dcq_cnt_if.dec cnt
);
  import dcq_pkg::*;

  logic a_q;
  logic b_q;
  logic a_rise;
  logic b_rise;
  logic one_ch;
  logic quad_up;
  logic next_up;
  logic next_dn;

  assign a_rise = a_i & ~a_q;
  assign b_rise = b_i & ~b_q;
  // Both phases moving at once carries no direction, so it is dropped
  assign one_ch = (a_i ^ a_q) ^ (b_i ^ b_q);
  assign quad_up = (a_i ^ a_q) ? (a_i ^ b_i) : ~(a_i ^ b_i);
  assign next_up = (mode_i == DCQ_UPDN) ? (a_rise & ~b_rise) :
                   (mode_i == DCQ_PDIR) ? (a_rise & ~b_i) :
                   (mode_i == DCQ_QUAD) ? (one_ch & quad_up) : 1'b0;
  assign next_dn = (mode_i == DCQ_UPDN) ? (b_rise & ~a_rise) :
                   (mode_i == DCQ_PDIR) ? (a_rise & b_i) :
                   (mode_i == DCQ_QUAD) ? (one_ch & ~quad_up) : 1'b0;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      cnt.up <= 1'b0;
      cnt.dn <= 1'b0;
    end else begin
      a_q <= a_i;
      b_q <= b_i;
      cnt.up <= next_up;
      cnt.dn <= next_dn;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_updn_cancel: assert property (
    (mode_i == DCQ_UPDN) && a_rise && b_rise |=> !cnt.up && !cnt.dn)
    else $error("coincident up and down edges changed the count");
  a_pdir_dir: assert property (
    (mode_i == DCQ_PDIR) && a_rise |=> (cnt.up == !$past(b_i)) && (cnt.dn == $past(b_i)))
    else $error("pulse counted in the wrong direction");
  a_quad_step: assert property (
    (mode_i == DCQ_QUAD) && $changed(a_i) && $stable(b_i) |=> cnt.up ^ cnt.dn)
    else $error("quadrature transition gave no single count");
  c_quad_down: cover property ((mode_i == DCQ_QUAD) && cnt.dn);
endmodule
`default_nettype wire

/* File: rtl/dcq_top.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Dual and differential counter
// ----------------------------------------------------------------
// Summary of operation
// - Dual mode gives two 32-bit bidirectional counters
// - Each dual counter: preload, two strobes, presets
// - Inhibit stops counting and zeroes the rate
// - Inhibit is level high; others edge triggered
// - Strobes fast filter; other inputs select filter
// - Fast filter passes fast counts; slow filter few
// - Up/down edges; coincident edges cancel
// - Pulse counts, direction low up, high down
// - Quadrature counts every phase transition, four per cycle
// - Differential accumulator combines plus and minus loops
// - Differential: four presets, three strobes, two preloads
// - Differential edges except arm and inhibit levels
// - Marker, strobes fast; arm slow; others select
// - Home capture beats preload one beats two
// - Minus loop pulses act opposite to plus loop
// - Loops pick mode independently; off gives nothing
// - Armed home, next marker loads home position
// - Home found reported as a status flag
// - Each output follows its own preset pair
// - Preload edge loads value and sets flag
// - Strobe edge captures accumulator and sets flag
module dcq_top #(
  parameter int FAST_CYC = dcq_pkg::FAST_FILT_CYC,
  parameter int SLOW_CYC = dcq_pkg::SLOW_FILT_CYC,
  parameter int MS_CYC = dcq_pkg::MS_TICK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [11:0] in_i,
  output logic [3:0] out_o,
  input wire logic [dcq_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o
);
  import dcq_pkg::*;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  logic [7:0] fsel;
  logic [15:0] tbase;
  logic [31:0] pre [2];
  logic [31:0] home_pos;
  logic [31:0] on_p [4];
  logic [31:0] off_p [4];
  logic diff;
  logic osc_sel;
  logic home_cmd;
  logic [3:0] sfall;
  logic [3:0] out_en;
  dcq_mode_t mode0;
  dcq_mode_t mode1;
  logic wr_ctrl;
  logic wr_fsel;
  logic wr_tbase;
  logic wr_flag;
  logic wr_home;

  assign diff = ctrl[CTRL_DIFF];
  assign mode0 = dcq_mode_t'(ctrl[CTRL_MODE0 +: 2]);
  assign mode1 = dcq_mode_t'(ctrl[CTRL_MODE1 +: 2]);
  assign osc_sel = ctrl[CTRL_OSC] & ~diff;
  assign sfall = ctrl[CTRL_SFALL +: 4];
  assign out_en = ctrl[CTRL_OUTEN +: 4];
  assign home_cmd = ctrl[CTRL_HOME];
  assign wr_ctrl = wr_i && (addr_i == A_CTRL);
  assign wr_fsel = wr_i && (addr_i == A_FSEL);
  assign wr_tbase = wr_i && (addr_i == A_TBASE);
  assign wr_flag = wr_i && (addr_i == A_FLAG);
  assign wr_home = wr_i && (addr_i == A_HOME);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl <= CTRL_RST;
      fsel <= FSEL_RST;
      tbase <= TBASE_RST;
      home_pos <= WORD_RST;
    end else begin
      if (wr_ctrl) ctrl <= wdata_i;
      if (wr_fsel) fsel <= wdata_i[7:0];
      if (wr_tbase) tbase <= wdata_i[15:0];
      if (wr_home) home_pos <= wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Input filters and edges
  // ----------------------------------------------------------------
  logic [11:0] slow_sel;
  logic [11:0] lvl;
  logic [11:0] lvl_q;
  logic [11:0] rise;
  logic [11:0] fall;

  // Strobes and marker always fast; the arm input is slow in differential mode, else fsel[7] selects
  assign slow_sel[6:0] = fsel[6:0];
  assign slow_sel[7] = diff | fsel[7];
  assign slow_sel[11:8] = 4'h0;
  assign rise = lvl & ~lvl_q;
  assign fall = ~lvl & lvl_q;

  for (genvar i = 0; i < 12; i++) begin : g_filt
    dcq_filt #(.FAST_CYC(FAST_CYC), .SLOW_CYC(SLOW_CYC)) u_filt (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .raw_i(in_i[i]),
      .slow_i(slow_sel[i]),
      .level_o(lvl[i])
    );
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) lvl_q <= 12'h000;
    else lvl_q <= lvl;
  end

  // ----------------------------------------------------------------
  // Count decoding
  // ----------------------------------------------------------------
  dcq_cnt_if cnt0 ();
  dcq_cnt_if cnt1 ();

  dcq_dec u_dec0 (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .a_i(lvl[0]),
    .b_i(lvl[1]),
    .mode_i(mode0),
    .cnt(cnt0.dec)
  );

  dcq_dec u_dec1 (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .a_i(lvl[2]),
    .b_i(lvl[3]),
    .mode_i(mode1),
    .cnt(cnt1.dec)
  );

  logic [OSC_W-1:0] osc_cnt;
  logic osc_tick;
  logic signed [2:0] d_plus;
  logic signed [2:0] d_minus;
  logic signed [2:0] delta [2];

  assign osc_tick = (osc_cnt == OSC_LAST);
  assign d_plus = $signed({2'b00, cnt0.up}) - $signed({2'b00, cnt0.dn});
  assign d_minus = $signed({2'b00, cnt1.up}) - $signed({2'b00, cnt1.dn});
  // Minus loop subtracts, so loop directions give sum or difference
  assign delta[0] = diff ? (d_plus - d_minus) :
                    (osc_sel ? {2'b00, osc_tick} : d_plus);
  assign delta[1] = diff ? 3'sh0 : d_minus;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) osc_cnt <= '0;
    else osc_cnt <= osc_tick ? '0 : osc_cnt + 1'b1;
  end

  // ----------------------------------------------------------------
  // Home sequence
  // ----------------------------------------------------------------
  dcq_home_t home_st;
  dcq_home_t next_home;
  logic arm_ok;
  logic home_ev;

  // The arm level must persist until the marker; dropping it disarms
  assign arm_ok = diff & home_cmd & lvl[7];
  assign home_ev = (home_st == HOME_ARMED) & arm_ok & rise[11];

  always_comb begin
    case (home_st)
      HOME_IDLE: next_home = arm_ok ? HOME_ARMED : HOME_IDLE;
      HOME_ARMED: next_home = !arm_ok ? HOME_IDLE : (rise[11] ? HOME_DONE : HOME_ARMED);
      HOME_DONE: next_home = arm_ok ? HOME_DONE : HOME_IDLE;
      default: next_home = HOME_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) home_st <= HOME_IDLE;
    else home_st <= next_home;
  end

  // ----------------------------------------------------------------
  // Accumulators and rate
  // ----------------------------------------------------------------
  logic [31:0] acc [2];
  logic [31:0] run [2];
  logic [31:0] cpt [2];
  logic [31:0] next_acc [2];
  logic [31:0] load_val [2];
  logic [1:0] load;
  logic [1:0] inh;
  logic [1:0] pl_ev;
  logic [MS_W-1:0] ms_cnt;
  logic [15:0] tb_cnt;
  logic ms_tick;
  logic tb_end;

  assign inh[0] = lvl[6];
  assign inh[1] = lvl[7] & ~diff;
  assign pl_ev = rise[5:4];
  assign load[0] = home_ev | pl_ev[0] | (diff & pl_ev[1]);
  assign load_val[0] = home_ev ? home_pos : (pl_ev[0] ? pre[0] : pre[1]);
  assign load[1] = ~diff & pl_ev[1];
  assign load_val[1] = pre[1];
  assign ms_tick = (ms_cnt == MS_W'(MS_CYC - 1));
  assign tb_end = ms_tick && ((tb_cnt + 16'h1) >= tbase);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ms_cnt <= '0;
      tb_cnt <= 16'h0;
    end else begin
      ms_cnt <= ms_tick ? '0 : ms_cnt + 1'b1;
      if (tb_end) tb_cnt <= 16'h0;
      else if (ms_tick) tb_cnt <= tb_cnt + 16'h1;
    end
  end

  for (genvar c = 0; c < 2; c++) begin : g_cnt
    logic [31:0] dext;
    assign dext = {{29{delta[c][2]}}, delta[c]};
    assign next_acc[c] = load[c] ? load_val[c] :
                         (inh[c] ? acc[c] : acc[c] + dext);
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        acc[c] <= WORD_RST;
        run[c] <= WORD_RST;
        cpt[c] <= WORD_RST;
        pre[c] <= WORD_RST;
      end else begin
        acc[c] <= next_acc[c];
        run[c] <= inh[c] ? 32'h0 : (tb_end ? dext : run[c] + dext);
        cpt[c] <= inh[c] ? 32'h0 : (tb_end ? run[c] : cpt[c]);
        if (wr_i && (addr_i == A_PRE0 + ADDR_W'(c))) pre[c] <= wdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Strobes, presets, outputs and flags
  // ----------------------------------------------------------------
  logic [3:0] stb_ev;
  logic [3:0] stb_flag;
  logic [1:0] pl_flag;
  logic home_flag;
  logic [31:0] cap [4];
  logic [31:0] src [4];

  for (genvar k = 0; k < 4; k++) begin : g_ent
    logic win;
    logic ge_on;
    logic lt_off;
    // In differential mode the fourth strobe pin is the marker
    assign stb_ev[k] = (sfall[k] ? fall[8 + k] : rise[8 + k]) &
                       ((k == 3) ? ~diff : 1'b1);
    assign src[k] = (diff || (k < 2)) ? acc[0] : acc[1];
    assign ge_on = $signed(src[k]) >= $signed(on_p[k]);
    assign lt_off = $signed(src[k]) < $signed(off_p[k]);
    // A reversed pair gives a window that wraps around the ends
    assign win = ($signed(on_p[k]) <= $signed(off_p[k])) ? (ge_on & lt_off) :
                 (ge_on | lt_off);
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        cap[k] <= WORD_RST;
        stb_flag[k] <= 1'b0;
        on_p[k] <= WORD_RST;
        off_p[k] <= WORD_RST;
        out_o[k] <= 1'b0;
      end else begin
        if (stb_ev[k]) cap[k] <= src[k];
        stb_flag[k] <= stb_ev[k] | (stb_flag[k] & ~(wr_flag & wdata_i[FLG_STB + k]));
        if (wr_i && (addr_i == A_ON0 + ADDR_W'(k))) on_p[k] <= wdata_i;
        if (wr_i && (addr_i == A_OFF0 + ADDR_W'(k))) off_p[k] <= wdata_i;
        out_o[k] <= out_en[k] & win;
      end
    end
  end

  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pl_flag <= 2'b00;
      home_flag <= 1'b0;
    end else begin
      pl_flag <= pl_ev | (pl_flag & ~({2{wr_flag}} & wdata_i[FLG_PL +: 2]));
      home_flag <= home_ev | (home_flag & ~(wr_flag & wdata_i[FLG_HOME]));
    end
  end

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  logic [31:0] rd_val;
  logic [31:0] status;
  logic [1:0] idx;

  assign status = {18'h0, lvl[7], out_o, lvl[7:6], home_flag, pl_flag, stb_flag};

  always_comb begin
    rd_val = 32'h0;
    idx = 2'(addr_i);
    if (addr_i == A_CTRL) begin
      rd_val = ctrl;
    end else if (addr_i == A_FSEL) begin
      rd_val = {24'h0, fsel};
    end else if (addr_i == A_TBASE) begin
      rd_val = {16'h0, tbase};
    end else if (addr_i == A_FLAG) begin
      rd_val = status;
    end else if (addr_i < A_CAP0) begin
      rd_val = acc[addr_i[0]];
    end else if (addr_i < A_CPT0) begin
      idx = 2'(addr_i - A_CAP0);
      rd_val = cap[idx];
    end else if (addr_i < A_PRE0) begin
      rd_val = cpt[addr_i[0]];
    end else if (addr_i < A_HOME) begin
      rd_val = pre[addr_i[0]];
    end else if (addr_i == A_HOME) begin
      rd_val = home_pos;
    end else if (addr_i < A_OFF0) begin
      idx = 2'(addr_i - A_ON0);
      rd_val = on_p[idx];
    end else if (addr_i < A_OFF0 + 5'h04) begin
      idx = 2'(addr_i - A_OFF0);
      rd_val = off_p[idx];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) rdata_o <= 32'h0;
    else rdata_o <= rd_i ? rd_val : 32'h0;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_inhibit_hold: assert property (
    !diff && inh[1] && !load[1] |=> acc[1] == $past(acc[1]))
    else $error("count moved while inhibited");
  a_inhibit_rate: assert property (
    inh[0] |=> cpt[0] == 32'h0)
    else $error("rate not zero while inhibited");
  a_preload_load: assert property (
    pl_ev[0] && !home_ev |=> (acc[0] == $past(pre[0])) && pl_flag[0])
    else $error("preload edge did not load or flag");
  a_home_priority: assert property (
    home_ev |=> (acc[0] == $past(home_pos)) && home_flag)
    else $error("home capture lost priority");
  a_home_armed: assert property (
    home_ev |-> home_cmd && diff && $past(lvl[7]) && (home_st == HOME_ARMED))
    else $error("home capture without arming");
  a_strobe_cap: assert property (
    stb_ev[1] |=> (cap[1] == $past(src[1])) && stb_flag[1])
    else $error("strobe did not capture");
  a_minus_loop: assert property (
    diff && !inh[0] && !load[0] && cnt1.up && !cnt1.dn && !cnt0.up && !cnt0.dn
    |=> acc[0] == $past(acc[0]) - 32'h1)
    else $error("minus loop count not opposite");
  a_rate_hold: assert property (
    !tb_end && !inh[0] |=> $stable(cpt[0]))
    else $error("rate changed inside the interval");
  c_home_found: cover property (home_ev);
  c_home_vs_preload: cover property (home_ev && pl_ev[0]);
  c_two_strobes: cover property (stb_ev[0] && stb_ev[1]);
endmodule
`default_nettype wire

/* File: dv/dcq_field_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Field side: encoders, switches, index sensor
// ----------------------------------------------------------------
module dcq_field_model #(
  parameter int HOLD = 16
) (
  input wire logic clock_i,
  output logic [11:0] line_o
);
  initial line_o = 12'h000;

  // Every level is held past the slow filter, so direction never moves with a pulse edge
  task automatic drive(input logic [11:0] m, input logic [11:0] v);
    @(posedge clock_i);
    line_o <= (line_o & ~m) | (v & m);
    repeat (HOLD) @(posedge clock_i);
  endtask

  task automatic pulse(input logic [11:0] m);
    drive(m, m);
    drive(m, 12'h000);
  endtask

  // One full cycle on lines 0 and 1, first phase leading when up
  task automatic quad(input bit up);
    if (up) begin
      drive(12'h001, 12'h001);
      drive(12'h002, 12'h002);
      drive(12'h001, 12'h000);
      drive(12'h002, 12'h000);
    end else begin
      drive(12'h002, 12'h002);
      drive(12'h001, 12'h001);
      drive(12'h002, 12'h000);
      drive(12'h001, 12'h000);
    end
  endtask
endmodule
`default_nettype wire

/* File: dv/dcq_top_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR %s exp %h got %h", n, e, a); end end
module dcq_top_tb_top;
  import dcq_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] field;
  logic [3:0] outs;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rdata;
  logic rd_d = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] p, q, h, e;
  logic [31:0] ex, mk;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #20 clk = ~clk;

  dcq_top #(.FAST_CYC(4), .SLOW_CYC(8), .MS_CYC(20)) dcq_top_inst (
    .clk_i(clk), .rst_n_i(rst_n), .in_i(field), .out_o(outs),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr_en), .rd_i(rd_en), .rdata_o(rdata));

  dcq_field_model #(.HOLD(16)) dcq_field_model_inst (.clock_i(clk), .line_o(field));

  // ----------------------------------------------------------------
  // Bus tasks and result watcher
  // ----------------------------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] x, input logic [31:0] m);
    exp_q.push_back(x & m);
    msk_q.push_back(m);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d) begin
      // Pop once here; the compare macro names its arguments twice
      ex = exp_q.pop_front();
      mk = msk_q.pop_front();
      `CHK("rdata", ex, rdata & mk)
    end
    rd_d <= rd_en;
    cycles++;
    if (cycles == 8000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    p = $urandom(32'h8fa0);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(A_CTRL, CTRL_RST, 32'hffff_ffff);
    rd(A_TBASE, 32'h0000_03e8, 32'hffff_ffff);
    rd(5'h1f, 32'h0, 32'hffff_ffff);
    // Count inputs and inhibit on the slow filter, loads and marker fast
    wr(A_FSEL, 32'h0000_004f);
    rd(A_FSEL, 32'h0000_004f, 32'hffff_ffff);
    // Dual up/down, then coincident edges
    wr(A_CTRL, 32'h0000_0008);
    repeat (3) dcq_field_model_inst.pulse(12'h001);
    dcq_field_model_inst.pulse(12'h002);
    dcq_field_model_inst.pulse(12'h003);
    rd(A_ACC0, 32'h2, 32'hffff_ffff);
    // Counter two in pulse/direction
    repeat (2) dcq_field_model_inst.pulse(12'h004);
    dcq_field_model_inst.drive(12'h008, 12'h008);
    repeat (3) dcq_field_model_inst.pulse(12'h004);
    dcq_field_model_inst.drive(12'h008, 12'h000);
    rd(A_ACC0 + 5'h1, 32'hffff_ffff, 32'hffff_ffff);
    // Quadrature both ways
    wr(A_CTRL, 32'h0000_000c);
    dcq_field_model_inst.quad(1'b1);
    rd(A_ACC0, 32'h6, 32'hffff_ffff);
    dcq_field_model_inst.quad(1'b0);
    dcq_field_model_inst.quad(1'b0);
    rd(A_ACC0, 32'hffff_fffe, 32'hffff_ffff);
    // Inhibit freezes counting and zeroes the rate
    dcq_field_model_inst.drive(12'h040, 12'h040);
    dcq_field_model_inst.quad(1'b1);
    repeat (30) @(posedge clk);
    rd(A_ACC0, 32'hffff_fffe, 32'hffff_ffff);
    rd(A_CPT0, 32'h0, 32'hffff_ffff);
    rd(A_FLAG, 32'h80, 32'h80);
    dcq_field_model_inst.drive(12'h040, 12'h000);
    // Oscillator over a short timebase gives a fixed rate per interval
    wr(A_TBASE, 32'h0000_0005);
    wr(A_CTRL, 32'h0000_002c);
    repeat (250) @(posedge clk);
    rd(A_CPT0, 32'(5 * 20 / OSC_DIV), 32'hffff_ffff);
    wr(A_CTRL, 32'h0000_000c);
    // Preload twice without clearing the flag
    p = $urandom & 32'h0fff_ffff;
    wr(A_PRE0, p);
    dcq_field_model_inst.pulse(12'h010);
    rd(A_ACC0, p, 32'hffff_ffff);
    rd(A_FLAG, 32'h10, 32'h10);
    dcq_field_model_inst.quad(1'b1);
    dcq_field_model_inst.pulse(12'h010);
    rd(A_ACC0, p, 32'hffff_ffff);
    // Falling-edge strobe captures only on the fall
    wr(A_CTRL, 32'h0000_044c);
    // Rising strobes on counter one second set and counter two first set
    dcq_field_model_inst.pulse(12'h600);
    rd(A_CAP0 + 5'h1, p, 32'hffff_ffff);
    rd(A_CAP0 + 5'h2, 32'hffff_ffff, 32'hffff_ffff);
    dcq_field_model_inst.drive(12'h100, 12'h100);
    rd(A_FLAG, 32'h0, 32'h1);
    dcq_field_model_inst.quad(1'b1);
    dcq_field_model_inst.drive(12'h100, 12'h000);
    rd(A_CAP0, p + 32'h4, 32'hffff_ffff);
    rd(A_FLAG, 32'h1, 32'h1);
    wr(A_FLAG, 32'hffff_ffff);
    rd(A_FLAG, 32'h0, 32'h7f);
    // Output window on its own preset pair
    wr(A_ON0, p + 32'h1);
    wr(A_OFF0, p + 32'ha);
    repeat (4) @(posedge clk);
    `CHK("out0", 1'b1, outs[0])
    dcq_field_model_inst.quad(1'b0);
    dcq_field_model_inst.quad(1'b0);
    `CHK("out0", 1'b0, outs[0])
    // Differential loops
    e = p - 32'h4;
    wr(A_CTRL, 32'h0000_0001);
    dcq_field_model_inst.pulse(12'h001);
    dcq_field_model_inst.pulse(12'h004);
    dcq_field_model_inst.pulse(12'h005);
    dcq_field_model_inst.pulse(12'h004);
    wr(A_CTRL, 32'h0000_0019);
    dcq_field_model_inst.pulse(12'h004);
    rd(A_ACC0, e - 32'h1, 32'hffff_ffff);
    // Home: command before arm, arm held until the marker
    h = $urandom;
    q = $urandom;
    wr(A_HOME, h);
    wr(A_PRE0 + 5'h1, q);
    wr(A_CTRL, 32'h0000_4019);
    dcq_field_model_inst.drive(12'h080, 12'h080);
    dcq_field_model_inst.pulse(12'h800);
    rd(A_ACC0, h, 32'hffff_ffff);
    rd(A_FLAG, 32'h40, 32'h40);
    // Simultaneous loads resolve by rank
    dcq_field_model_inst.drive(12'h080, 12'h000);
    dcq_field_model_inst.pulse(12'h001);
    dcq_field_model_inst.drive(12'h080, 12'h080);
    dcq_field_model_inst.pulse(12'h830);
    rd(A_ACC0, h, 32'hffff_ffff);
    dcq_field_model_inst.pulse(12'h030);
    rd(A_ACC0, p, 32'hffff_ffff);
    dcq_field_model_inst.pulse(12'h020);
    rd(A_ACC0, q, 32'hffff_ffff);
    repeat (4) @(posedge clk);
    wrap_up();
  end
endmodule
`default_nettype wire
